// >>> core/cp_handshake_port.sv
// Processor-side coprocessor handshake and status port
`timescale 1ns/1ps
// Summary of operation
// - Outputs change and inputs sampled only on rising clock edge, apart from asynchronous reset.
// - Cycle-advance enable low holds all state and outputs for whole cycles.
// - Static clock in either phase keeps all state; design is fully static.
// - Coprocessor instruction drives coproc_instr_n low, awaits absent/busy.
// - Absent high during executed coprocessor cycle raises undefined trap.
// - Absent low: wait while busy high, complete when busy low.
// - mem_request_n low exactly when next transaction needs memory.
// - opcode_fetch_n low for instruction fetch, high for data.
// - sequential_access high for same address, +4 wide, +2 narrow fetch.
// - narrow_isa_state high in narrow set, low in wide set.
// - privileged_translate_n low in user mode, high when privileged.
module cp_handshake_port
  import cp_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cycle_advance_enable,
  input wire logic i_cp_start,
  input wire mem_req_t i_req,
  input wire core_state_t i_core,
  input wire logic i_coproc_absent,
  input wire logic i_coproc_busy,
  output logic o_coproc_instr_n,
  output logic o_mem_request_n,
  output logic o_opcode_fetch_n,
  output logic o_sequential_access,
  output logic o_narrow_isa_state,
  output logic o_privileged_translate_n,
  output logic o_cp_done,
  output logic o_cp_undef
);

  typedef struct packed {
    cp_state_t   st;
    logic        instr_n;
    logic        mreq_n;
    logic        opc_n;
    logic        seq;
    logic        narrow;
    logic        trans_n;
    logic [31:0] prev_addr;
    logic        prev_valid;
    cp_result_t  res;
  } port_state_t;

  port_state_t state_q;
  port_state_t state_d;
  logic seq_next;

  // Reset image of the whole port state
  localparam port_state_t RESET_STATE = '{
    st: CP_IDLE,
    instr_n: RST_INSTR_N,
    mreq_n: RST_MREQ_N,
    opc_n: RST_OPC_N,
    seq: 1'b0,
    narrow: 1'b0,
    trans_n: RST_TRANS_N,
    prev_addr: '0,
    prev_valid: 1'b0,
    res: '0
  };

  // Status lines for the next transaction, from the core's view
  function automatic port_state_t status_step(input port_state_t s,
                                              input mem_req_t r,
                                              input core_state_t c,
                                              input logic seq);
    port_state_t n;
    n = s;
    n.mreq_n = ~r.valid;
    n.opc_n = ~(r.valid & r.opcode);
    n.seq = seq;
    // Idle cycles keep the last address so a later access can still chain
    if (r.valid) begin
      n.prev_addr = r.addr;
      n.prev_valid = 1'b1;
    end
    n.narrow = c.narrow_isa;
    n.trans_n = ~c.user_mode;
    return n;
  endfunction

  // Ends a handshake: instruction line released, one result pulse raised
  function automatic port_state_t close_hs(input port_state_t s,
                                           input logic undef);
    port_state_t n;
    n = s;
    n.st = CP_IDLE;
    n.instr_n = RST_INSTR_N;
    n.res.undef = undef;
    n.res.done = ~undef;
    return n;
  endfunction

  // One enabled step of the coprocessor handshake
  function automatic port_state_t hs_step(input port_state_t s,
                                          input logic start,
                                          input logic absent,
                                          input logic busy);
    port_state_t n;
    n = s;
    unique case (s.st)
      CP_IDLE: begin
        if (start) begin
          n.st = CP_WAIT;
          n.instr_n = 1'b0;
        end
      end
      CP_WAIT, CP_EXEC: begin
        // Absent is checked on every waiting edge, so a late refusal aborts
        // absent aborts
        if (absent) begin
          n = close_hs(s, 1'b1);
        end else if (busy) begin
          n.st = CP_WAIT;
        end else begin
          n = close_hs(s, 1'b0);
        end
      end
      // A corrupted state code drops the handshake without a result
      default: begin
        n.st = CP_IDLE;
        n.instr_n = RST_INSTR_N;
      end
    endcase
    return n;
  endfunction

  seq_detect u_seq (
    .i_prev_addr (state_q.prev_addr),
    .i_prev_valid(state_q.prev_valid),
    .i_req       (i_req),
    .i_narrow_isa(i_core.narrow_isa),
    .o_seq       (seq_next)
  );

  always_comb begin
    state_d = state_q;
    if (i_cycle_advance_enable) begin
      state_d.res = '0;
      state_d = status_step(state_d, i_req, i_core, seq_next);
      state_d = hs_step(state_d, i_cp_start, i_coproc_absent,
                        i_coproc_busy);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_coproc_instr_n = state_q.instr_n;
  assign o_mem_request_n = state_q.mreq_n;
  assign o_opcode_fetch_n = state_q.opc_n;
  assign o_sequential_access = state_q.seq;
  assign o_narrow_isa_state = state_q.narrow;
  assign o_privileged_translate_n = state_q.trans_n;
  assign o_cp_done = state_q.res.done;
  assign o_cp_undef = state_q.res.undef;

endmodule // cp_handshake_port

// >>> core/cp_port_pkg.sv
// Package of types and constants for the coprocessor handshake port
package cp_port_pkg;

  // Address step for a sequential wide-instruction access
  localparam logic [31:0] WIDE_STEP = 32'h0000_0004;
  // Address step for a sequential narrow opcode fetch
  localparam logic [31:0] NARROW_STEP = 32'h0000_0002;
  // Reset values of the active-low status outputs (inactive)
  localparam logic RST_INSTR_N = 1'b1;
  localparam logic RST_MREQ_N = 1'b1;
  localparam logic RST_OPC_N = 1'b1;
  localparam logic RST_TRANS_N = 1'b1;

  // Request from the core pipeline for the next memory transaction
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        opcode;
  } mem_req_t;

  // Core state visible to the coprocessor
  typedef struct packed {
    logic narrow_isa;
    logic user_mode;
  } core_state_t;

  // Handshake result pulses back to the core
  typedef struct packed {
    logic done;
    logic undef;
  } cp_result_t;

  typedef enum logic [1:0] {
    CP_IDLE,
    CP_WAIT,
    CP_EXEC
  } cp_state_t;

endpackage

// >>> core/seq_detect.sv
// Sequential-address classifier for the next memory transaction
`timescale 1ns/1ps
module seq_detect
  import cp_port_pkg::*;
(
  input wire logic [31:0] i_prev_addr,
  input wire logic i_prev_valid,
  input wire mem_req_t i_req,
  input wire logic i_narrow_isa,
  output logic o_seq
);

  function automatic logic is_step(input logic [31:0] a,
                                   input logic [31:0] b,
                                   input logic [31:0] s);
    is_step = (a == 32'(b + s));
  endfunction

  always_comb begin
    o_seq = 1'b0;
    if (i_req.valid && i_prev_valid) begin
      if (i_req.addr == i_prev_addr)
        o_seq = 1'b1;
      else if (!i_narrow_isa && is_step(i_req.addr, i_prev_addr, WIDE_STEP))
        o_seq = 1'b1;
      else if (i_narrow_isa && i_req.opcode &&
               is_step(i_req.addr, i_prev_addr, NARROW_STEP))
        o_seq = 1'b1;
    end
  end

endmodule // seq_detect

// >>> verif/cp_port_assertions.sv
// Checker for the coprocessor handshake port
`timescale 1ns/1ps
module cp_port_assertions
  import cp_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cycle_advance_enable,
  input wire logic i_cp_start,
  input wire mem_req_t i_req,
  input wire core_state_t i_core,
  input wire logic i_coproc_absent,
  input wire logic i_coproc_busy,
  input wire logic o_coproc_instr_n,
  input wire logic o_mem_request_n,
  input wire logic o_opcode_fetch_n,
  input wire logic o_sequential_access,
  input wire logic o_narrow_isa_state,
  input wire logic o_privileged_translate_n,
  input wire logic o_cp_done,
  input wire logic o_cp_undef
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire en = i_cycle_advance_enable;
  wire sel = en && !o_coproc_instr_n;
  sequence up; $past(en) && $past(i_arst_n); endsequence
  sequence go; sel && !i_coproc_absent && !i_coproc_busy; endsequence
  req_a: assert property (up |-> o_mem_request_n != $past(i_req.valid))
    else $error("req");
  opc_a: assert property (up |->
    o_opcode_fetch_n != ($past(i_req.valid) && $past(i_req.opcode)))
    else $error("opc");
  isa_a: assert property (up |->
    o_narrow_isa_state == $past(i_core.narrow_isa)) else $error("isa");
  priv_a: assert property (up |->
    o_privileged_translate_n != $past(i_core.user_mode)) else $error("pv");
  hold_a: assert property (!$past(en) |-> $stable(o_coproc_instr_n))
    else $error("hold");
  start_a: assert property (en && o_coproc_instr_n && i_cp_start |=>
    !o_coproc_instr_n) else $error("start");
  undef_a: assert property (sel && i_coproc_absent |=> o_cp_undef)
    else $error("undef");
  done_a: assert property (go |=> o_cp_done && o_coproc_instr_n)
    else $error("done");
  seq_gap_a: assert property ($past(en) && !$past(i_req.valid) |->
    !o_sequential_access) else $error("seq");
  pulse_len_a: assert property (en && (o_cp_done || o_cp_undef) |=>
    !o_cp_done && !o_cp_undef) else $error("pulse");
endmodule // cp_port_assertions
bind cp_handshake_port cp_port_assertions u_chk (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_cycle_advance_enable(i_cycle_advance_enable),
  .i_cp_start(i_cp_start),
  .i_req(i_req),
  .i_core(i_core),
  .i_coproc_absent(i_coproc_absent),
  .i_coproc_busy(i_coproc_busy),
  .o_coproc_instr_n(o_coproc_instr_n),
  .o_mem_request_n(o_mem_request_n),
  .o_opcode_fetch_n(o_opcode_fetch_n),
  .o_sequential_access(o_sequential_access),
  .o_narrow_isa_state(o_narrow_isa_state),
  .o_privileged_translate_n(o_privileged_translate_n),
  .o_cp_done(o_cp_done),
  .o_cp_undef(o_cp_undef)
);

// >>> verif/cp_model.sv
// Behavioural coprocessor on the far side of the port
`timescale 1ns/1ps
module cp_model (
  input wire logic i_clk, i_cycle_advance_enable, o_coproc_instr_n, refuse,
  input wire logic [3:0] wait_len,
  output logic i_coproc_absent, i_coproc_busy
);
  logic [3:0] cnt_q = 4'h0;
  always @(posedge i_clk)
    if (i_cycle_advance_enable) cnt_q <= o_coproc_instr_n ? 4'h0 : cnt_q + 4'h1;
  // settled answer; idle lines float high
  assign i_coproc_absent = o_coproc_instr_n ? 1'b1 : refuse;
  assign i_coproc_busy = o_coproc_instr_n ? 1'b1 : cnt_q < wait_len;
endmodule // cp_model

// >>> verif/tb_coprocessor_handshake_port.sv
// Testbench for the coprocessor handshake port
`timescale 1ns/1ps
module tb_coprocessor_handshake_port import cp_port_pkg::*;;
  logic i_clk = 1'h0, i_arst_n = 1'h0, i_cycle_advance_enable = 1'h1;
  logic i_cp_start = 1'h0, refuse = 1'h0, i_coproc_absent, i_coproc_busy;
  logic o_coproc_instr_n, o_mem_request_n, o_opcode_fetch_n, o_cp_done;
  logic o_sequential_access, o_narrow_isa_state, o_privileged_translate_n;
  logic o_cp_undef;
  logic [3:0] wait_len = 4'h0;
  mem_req_t i_req = '0;
  core_state_t i_core = '0;
  int n_fail = 0, tests_run = 0, cyc = 0;
  always #12.5 i_clk = ~i_clk;
  cp_handshake_port i_dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_cycle_advance_enable(i_cycle_advance_enable),
    .i_cp_start(i_cp_start),
    .i_req(i_req),
    .i_core(i_core),
    .i_coproc_absent(i_coproc_absent),
    .i_coproc_busy(i_coproc_busy),
    .o_coproc_instr_n(o_coproc_instr_n),
    .o_mem_request_n(o_mem_request_n),
    .o_opcode_fetch_n(o_opcode_fetch_n),
    .o_sequential_access(o_sequential_access),
    .o_narrow_isa_state(o_narrow_isa_state),
    .o_privileged_translate_n(o_privileged_translate_n),
    .o_cp_done(o_cp_done),
    .o_cp_undef(o_cp_undef)
  );
  cp_model i_cp (
    .i_clk(i_clk),
    .i_cycle_advance_enable(i_cycle_advance_enable),
    .o_coproc_instr_n(o_coproc_instr_n),
    .refuse(refuse),
    .wait_len(wait_len),
    .i_coproc_absent(i_coproc_absent),
    .i_coproc_busy(i_coproc_busy)
  );
  task check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("%0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Flags are valid, opcode fetch, narrow set
  task seq_test(input logic [2:0] f, input logic [31:0] a, input logic s);
    @(posedge i_clk);
    i_req <= '{f[2], a, f[1]};
    i_core <= '{f[0], !f[0]};
    @(posedge i_clk);
    #1;
    check(o_sequential_access, s);
    $display("sequence test done");
  endtask
  task cp_test(input logic a, input logic [3:0] w, input int st);
    int n;
    n = 0;
    @(posedge i_clk);
    refuse <= a;
    wait_len <= w;
    i_cp_start <= 1'h1;
    @(posedge i_clk);
    i_cp_start <= 1'h0;
    i_cycle_advance_enable <= st == 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n == st) i_cycle_advance_enable <= 1'h1;
      #1;
    end while (o_cp_done !== 1'h1 && o_cp_undef !== 1'h1 && n < 40);
    check(n, a ? st + 1 : w + st + 1);
    check({o_cp_done, o_cp_undef}, {!a, a});
    $display("handshake test done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'h1;
    seq_test(3'h6, 32'h100, 1'h0);
    seq_test(3'h6, 32'h104, 1'h1);
    seq_test(3'h4, 32'h104, 1'h1);
    seq_test(3'h7, 32'h106, 1'h1);
    seq_test(3'h5, 32'h108, 1'h0);
    seq_test(3'h0, 32'h108, 1'h0);
    seq_test(3'h2, 32'h200, 1'h0);
    seq_test(3'h4, 32'h10C, 1'h1);
    cp_test(1'h0, 4'h0, 0);
    cp_test(1'h0, 4'h3, 0);
    cp_test(1'h1, 4'h0, 0);
    cp_test(1'h0, 4'h2, 3);
    cp_test(1'h1, 4'h0, 2);
    complete_run;
  end
  // Run takes about forty-five cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      complete_run;
    end
  end
endmodule // tb_coprocessor_handshake_port
